// *** rtl/eeprom_access_pkg.sv ***
package eeprom_access_pkg;
  // i/o space locations of the four access registers
  localparam logic [5:0] IDX_HIGH_OFS = 6'h1F;
  localparam logic [5:0] IDX_LOW_OFS = 6'h1E;
  localparam logic [5:0] BUFFER_OFS = 6'h1D;
  localparam logic [5:0] CONTROL_OFS = 6'h1C;
  // control byte fields
  localparam int READY_IRQ_EN_BIT = 3;
  localparam int WRITE_ARM_BIT = 2;
  localparam int WRITE_STROBE_BIT = 1;
  localparam int READ_STROBE_BIT = 0;
  localparam int INDEX_W = 9;
  // values after reset
  localparam logic [8:0] INDEX_RESET = 9'h000;
  localparam logic [7:0] BUFFER_RESET = 8'h00;
  // arm window and processor stalls
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
  localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
  // self-timed write, counted on the 1 MHz rc oscillator
  localparam int RC_FREQ_HZ = 1000000;
  localparam real WRITE_TIME_MS = 8.5;
  localparam int WRITE_RC_TICKS = 8448;
  localparam int SYS_FREQ_HZ = 10000000;
  localparam int SYS_PER_RC = SYS_FREQ_HZ / RC_FREQ_HZ;
endpackage

// *** rtl/eeprom_cpu_access_control.sv ***
// Contract
// RULE1: nine-bit index selects one of 512 bytes
// RULE2: reserved high bits read as zero
// RULE3: software loads index before any access
// RULE4: buffer holds write data or read result
// RULE5: ready irq asserted while strobe reads zero
// RULE6: strobe without arm starts no write
// RULE7: arm clears itself four cycles later
// RULE8: software arms then strobes within four cycles
// RULE9: no write while flash self-programming busy
// RULE10: software keeps interrupts off during sequence
// RULE11: strobe clears when write time elapses
// RULE12: write start stalls processor two cycles
// RULE13: read loads buffer, stalls four cycles
// RULE14: busy write blocks reads and index writes
// RULE15: write timed by 8448 rc ticks
// RULE16: write completes in sleep, oscillator kept on
// RULE17: registers live in processor i/o space
// RULE18: reset during write lets write complete
// RULE19: read strobe clears itself when done
// RULE20: strobe captures index and data
`timescale 1ns/10ps
`default_nettype none
module eeprom_cpu_access_control
  import eeprom_access_pkg::*;
#(
  parameter int WRITE_TICKS = WRITE_RC_TICKS
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic porRst,
  input wire logic clkEn,
  input wire logic [5:0] ioAddr,
  input wire logic ioWrite,
  input wire logic [7:0] ioWdata,
  output logic [7:0] ioRdata_r,
  input wire logic globalIrqEnable,
  input wire logic flashSelfprogBusy,
  input wire logic rcOscClk,
  output logic readyIrq_r,
  output logic cpuStall_r,
  output logic rcOscRequest_r,
  output logic [8:0] cellAddr_r,
  output logic [7:0] cellWdata_r,
  output logic cellWrite_r,
  output logic cellRead_r,
  input wire logic [7:0] cellRdata
);
  // register file and access sequencing (system reset)
  logic [8:0] index_r, index_nxt;
  logic [7:0] buffer_r, buffer_nxt;
  logic irqEn_r, irqEn_nxt;
  logic arm_r, arm_nxt;
  logic [2:0] armCnt_r, armCnt_nxt;
  logic readPend_r, readPend_nxt;
  logic [2:0] stallCnt_r, stallCnt_nxt;
  logic [7:0] ioRdata_nxt;
  logic readyIrq_nxt, cpuStall_nxt, cellRead_nxt;
  // write engine (power-on reset only)
  logic busy_r, busy_nxt;
  logic [13:0] tickCnt_r, tickCnt_nxt;
  logic [8:0] cellAddr_nxt;
  logic [7:0] cellWdata_nxt;
  logic rcSync1_r, rcSync2_r, rcPrev_r;
  logic wrIdxHigh, wrIdxLow, wrBuffer, wrControl, startWrite, startRead;
  logic rcTick;

  // i/o write hit on one register location
  function automatic logic ioHit(input logic wr, input logic [5:0] adr,
    input logic [5:0] ofs);
    return wr && (adr == ofs);
  endfunction

  // decode of processor i/o writes
  assign wrIdxHigh = ioHit(ioWrite, ioAddr, IDX_HIGH_OFS);
  assign wrIdxLow = ioHit(ioWrite, ioAddr, IDX_LOW_OFS);
  assign wrBuffer = ioHit(ioWrite, ioAddr, BUFFER_OFS);
  assign wrControl = ioHit(ioWrite, ioAddr, CONTROL_OFS);
  // RULE6: arm gates the strobe
  // RULE9: flash busy refuses start
  assign startWrite = wrControl && ioWdata[WRITE_STROBE_BIT] && arm_r
    && !busy_r && !flashSelfprogBusy;
  // RULE14: reads refused during write
  assign startRead = wrControl && ioWdata[READ_STROBE_BIT] && !busy_r
    && !readPend_r;
  // rising edge of the synchronised oscillator
  assign rcTick = rcSync2_r && !rcPrev_r;

  // next state of registers and sequencing
  always_comb
  begin
    index_nxt = index_r;
    buffer_nxt = buffer_r;
    irqEn_nxt = irqEn_r;
    arm_nxt = arm_r;
    armCnt_nxt = armCnt_r;
    readPend_nxt = readPend_r;
    stallCnt_nxt = stallCnt_r;
    cellRead_nxt = 1'b0;
    // RULE17: i/o space register writes
    // RULE1: nine-bit index over two bytes
    // RULE14: index frozen while busy
    if (wrIdxHigh && !busy_r)
      index_nxt[8] = ioWdata[0];
    if (wrIdxLow && !busy_r)
      index_nxt[7:0] = ioWdata;
    // RULE4: buffer takes write data
    if (wrBuffer)
      buffer_nxt = ioWdata;
    // RULE7: arm counts down four cycles
    if (armCnt_r != 3'h0)
      armCnt_nxt = armCnt_r - 3'h1;
    if (armCnt_r == 3'h1)
      arm_nxt = 1'b0;
    if (wrControl)
    begin
      irqEn_nxt = ioWdata[READY_IRQ_EN_BIT];
      if (ioWdata[WRITE_ARM_BIT])
      begin
        arm_nxt = 1'b1;
        armCnt_nxt = ARM_CYCLES;
      end
    end
    if (startWrite)
    begin
      arm_nxt = 1'b0;
      armCnt_nxt = 3'h0;
    end
    // RULE13: read fetch, then buffer load
    if (startRead)
    begin
      readPend_nxt = 1'b1;
      cellRead_nxt = 1'b1;
    end
    // RULE19: read strobe self-clears
    if (readPend_r && !cellRead_r)
      readPend_nxt = 1'b0;
    if (cellRead_r)
      buffer_nxt = cellRdata;
    if (stallCnt_r != 3'h0)
      stallCnt_nxt = stallCnt_r - 3'h1;
    // RULE12: two-cycle write stall
    if (startWrite)
      stallCnt_nxt = WRITE_STALL_CYCLES;
    // RULE13: four-cycle read stall
    else if (startRead)
      stallCnt_nxt = READ_STALL_CYCLES;
    cpuStall_nxt = stallCnt_nxt != 3'h0;
    // RULE5: level irq while strobe zero
    readyIrq_nxt = irqEn_nxt && globalIrqEnable && !busy_nxt;
    // RULE2: reserved bits read zero
    unique case (ioAddr)
      IDX_HIGH_OFS: ioRdata_nxt = {7'h00, index_nxt[8]};
      IDX_LOW_OFS: ioRdata_nxt = index_nxt[7:0];
      BUFFER_OFS: ioRdata_nxt = buffer_nxt;
      CONTROL_OFS: ioRdata_nxt = {4'h0, irqEn_nxt, arm_nxt, busy_nxt,
        readPend_nxt};
      default: ioRdata_nxt = 8'h00;
    endcase
  end

  // register file flops
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      index_r <= INDEX_RESET;
      buffer_r <= BUFFER_RESET;
      irqEn_r <= 1'b0;
      arm_r <= 1'b0;
      armCnt_r <= 3'h0;
      readPend_r <= 1'b0;
      stallCnt_r <= 3'h0;
      ioRdata_r <= 8'h00;
      readyIrq_r <= 1'b0;
      cpuStall_r <= 1'b0;
      cellRead_r <= 1'b0;
    end
    else if (clkEn)
    begin
      index_r <= index_nxt;
      buffer_r <= buffer_nxt;
      irqEn_r <= irqEn_nxt;
      arm_r <= arm_nxt;
      armCnt_r <= armCnt_nxt;
      readPend_r <= readPend_nxt;
      stallCnt_r <= stallCnt_nxt;
      ioRdata_r <= ioRdata_nxt;
      readyIrq_r <= readyIrq_nxt;
      cpuStall_r <= cpuStall_nxt;
      cellRead_r <= cellRead_nxt;
    end
  end

  // next state of the write engine
  always_comb
  begin
    busy_nxt = busy_r;
    tickCnt_nxt = tickCnt_r;
    cellWdata_nxt = cellWdata_r;
    cellAddr_nxt = busy_r ? cellAddr_r : index_nxt;
    // RULE20: capture index and data
    if (startWrite)
    begin
      busy_nxt = 1'b1;
      tickCnt_nxt = 14'h0000;
      cellAddr_nxt = index_r;
      cellWdata_nxt = buffer_r;
    end
    // RULE15: count rc oscillator ticks
    else if (busy_r && rcTick)
    begin
      tickCnt_nxt = tickCnt_r + 14'h0001;
      // RULE11: strobe cleared at end
      if (tickCnt_r == 14'(WRITE_TICKS - 1))
        busy_nxt = 1'b0;
    end
  end

  // write engine flops, untouched by system reset
  // RULE18: write survives system reset
  // RULE16: oscillator held while writing
  always_ff @(posedge clk_sys or posedge porRst)
  begin
    if (porRst)
    begin
      busy_r <= 1'b0;
      tickCnt_r <= 14'h0000;
      cellAddr_r <= 9'h000;
      cellWdata_r <= 8'h00;
      cellWrite_r <= 1'b0;
      rcOscRequest_r <= 1'b0;
      rcSync1_r <= 1'b0;
      rcSync2_r <= 1'b0;
      rcPrev_r <= 1'b0;
    end
    else if (clkEn)
    begin
      busy_r <= busy_nxt;
      tickCnt_r <= tickCnt_nxt;
      cellAddr_r <= cellAddr_nxt;
      cellWdata_r <= cellWdata_nxt;
      cellWrite_r <= busy_nxt;
      rcOscRequest_r <= busy_nxt;
      rcSync1_r <= rcOscClk;
      rcSync2_r <= rcSync1_r;
      rcPrev_r <= rcSync2_r;
    end
  end
endmodule
`default_nettype wire

// *** testbench/eeprom_cpu_access_control_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module eeprom_cpu_access_control_asserts
  import eeprom_access_pkg::*;
#(
  parameter int WRITE_TICKS = WRITE_RC_TICKS
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic porRst,
  input wire logic clkEn,
  input wire logic [5:0] ioAddr,
  input wire logic ioWrite,
  input wire logic [7:0] ioWdata,
  input wire logic [7:0] ioRdata_r,
  input wire logic globalIrqEnable,
  input wire logic readyIrq_r,
  input wire logic cpuStall_r,
  input wire logic rcOscRequest_r,
  input wire logic [8:0] cellAddr_r,
  input wire logic [7:0] cellWdata_r,
  input wire logic cellWrite_r,
  input wire logic cellRead_r
);
  // write length bounds in system cycles, sync latency included
  localparam int WMIN = (WRITE_TICKS - 1) * SYS_PER_RC;
  localparam int WMAX = WRITE_TICKS * SYS_PER_RC + 4;
  logic rdGo;
  logic [31:0] wrLen_r;
  // read request taken while idle
  assign rdGo = clkEn && ioWrite && ioAddr == CONTROL_OFS
    && ioWdata[READ_STROBE_BIT] && !cellWrite_r && !cellRead_r
    && !cpuStall_r;
  // cycles spent in the current write
  always_ff @(posedge clk_sys or posedge porRst)
  begin
    if (porRst)
      wrLen_r <= 32'h00000000;
    else if (!cellWrite_r)
      wrLen_r <= 32'h00000000;
    else if (clkEn)
      wrLen_r <= wrLen_r + 32'h00000001;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst || porRst);
  a_ctrl_zero: assert property (clkEn && ioAddr == CONTROL_OFS
    |=> ioRdata_r[7:4] == 4'h0) else $error("control top bits set");
  a_high_zero: assert property (clkEn && ioAddr == IDX_HIGH_OFS
    |=> ioRdata_r[7:1] == 7'h00) else $error("index high bits set");
  a_no_read_busy: assert property (cellWrite_r |=> !cellRead_r)
    else $error("read during write");
  a_read_stall: assert property (rdGo |=> (cellRead_r && cpuStall_r)
    ##1 (!cellRead_r && cpuStall_r) [*3] ##1 !cpuStall_r)
    else $error("bad read stall");
  a_write_stall: assert property ($rose(cellWrite_r) |-> cpuStall_r
    [*2] ##1 !cpuStall_r) else $error("bad write stall");
  a_irq_busy: assert property (cellWrite_r |-> !readyIrq_r)
    else $error("irq while writing");
  a_irq_global: assert property (!globalIrqEnable |=> !readyIrq_r)
    else $error("irq without global enable");
  a_osc_on: assert property (cellWrite_r |-> rcOscRequest_r)
    else $error("oscillator off in write");
  a_capture: assert property (cellWrite_r && $past(cellWrite_r)
    |-> $stable(cellAddr_r) && $stable(cellWdata_r)) else $error("moved");
  a_write_len: assert property ($fell(cellWrite_r)
    |-> wrLen_r >= WMIN && wrLen_r <= WMAX) else $error("write length off");
  // main scenarios reached
  c_read: cover property (rdGo);
  c_write: cover property ($rose(cellWrite_r));
  c_irq: cover property ($rose(readyIrq_r));
endmodule
`default_nettype wire

// *** testbench/eeprom_cpu_access_control_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module eeprom_cpu_access_control_tb_top
  import eeprom_access_pkg::*;
;
  localparam int WT = 8;
  logic clk_sys = 1'b0;
  logic rst, porRst, ioWrite, globalIrqEnable, flashSelfprogBusy, rcOscClk;
  logic readyIrq_r, cpuStall_r, rcOscRequest_r, cellWrite_r, cellRead_r;
  logic clkEn;
  logic [5:0] ioAddr;
  logic [7:0] ioWdata, ioRdata_r, cellWdata_r, cellRdata;
  logic [8:0] cellAddr_r;
  int num_errors = 0;
  int n_compared = 0;
  int n;
  eeprom_cpu_access_control #(.WRITE_TICKS(WT)) dut (
    .clk_sys(clk_sys), .rst(rst), .porRst(porRst), .clkEn(clkEn),
    .ioAddr(ioAddr), .ioWrite(ioWrite), .ioWdata(ioWdata),
    .ioRdata_r(ioRdata_r), .globalIrqEnable(globalIrqEnable),
    .flashSelfprogBusy(flashSelfprogBusy), .rcOscClk(rcOscClk),
    .readyIrq_r(readyIrq_r), .cpuStall_r(cpuStall_r),
    .rcOscRequest_r(rcOscRequest_r), .cellAddr_r(cellAddr_r),
    .cellWdata_r(cellWdata_r), .cellWrite_r(cellWrite_r),
    .cellRead_r(cellRead_r), .cellRdata(cellRdata));
  // clocks and cell array stand-in
  always #50 clk_sys = ~clk_sys;
  assign cellRdata = ~cellAddr_r[7:0];
  initial
  begin
    rcOscClk = 1'b0;
    #25;
    forever #500 rcOscClk = ~rcOscClk;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {ioAddr, ioWdata, ioWrite} = {a, d, 1'b1};
    @(negedge clk_sys);
    ioWrite = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    ioAddr = a;
    @(negedge clk_sys);
    chk({1'b0, ioRdata_r}, {1'b0, e});
  endtask
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #200000;
    num_errors++;
    test_done;
  end
  // register accesses, read, refused and real writes
  initial
  begin
    {ioAddr, ioWdata, ioWrite, globalIrqEnable, flashSelfprogBusy} = '0;
    clkEn = 1'b1;
    {rst, porRst} = 2'h3;
    repeat (12) @(negedge clk_sys);
    {rst, porRst} = 2'h0;
    rd(CONTROL_OFS, 8'h00);
    wr(IDX_HIGH_OFS, 8'hFF);
    rd(IDX_HIGH_OFS, 8'h01);
    wr(IDX_LOW_OFS, 8'h5A);
    rd(IDX_LOW_OFS, 8'h5A);
    // frozen clock enable drops the index write
    clkEn = 1'b0;
    wr(IDX_LOW_OFS, 8'h99);
    clkEn = 1'b1;
    rd(IDX_LOW_OFS, 8'h5A);
    wr(BUFFER_OFS, 8'h3C);
    rd(BUFFER_OFS, 8'h3C);
    wr(CONTROL_OFS, 8'h01);
    rd(BUFFER_OFS, 8'hA5);
    rd(CONTROL_OFS, 8'h00);
    wr(CONTROL_OFS, 8'h02);
    rd(CONTROL_OFS, 8'h00);
    wr(CONTROL_OFS, 8'h04);
    rd(CONTROL_OFS, 8'h04);
    repeat (4) @(negedge clk_sys);
    rd(CONTROL_OFS, 8'h00);
    flashSelfprogBusy = 1'b1;
    wr(CONTROL_OFS, 8'h04);
    wr(CONTROL_OFS, 8'h02);
    repeat (6) @(negedge clk_sys);
    rd(CONTROL_OFS, 8'h00);
    flashSelfprogBusy = 1'b0;
    wr(IDX_HIGH_OFS, 8'h01);
    wr(IDX_LOW_OFS, 8'h23);
    wr(BUFFER_OFS, 8'h77);
    // arm then strobe within four cycles
    wr(CONTROL_OFS, 8'h0C);
    wr(CONTROL_OFS, 8'h0E);
    globalIrqEnable = 1'b1;
    @(negedge clk_sys);
    chk(cellAddr_r, 9'h123);
    chk(cellWdata_r, 9'h077);
    chk(readyIrq_r, 9'h000);
    wr(IDX_LOW_OFS, 8'h00);
    rd(IDX_LOW_OFS, 8'h23);
    wr(BUFFER_OFS, 8'h11);
    wr(CONTROL_OFS, 8'h09);
    rd(BUFFER_OFS, 8'h11);
    rd(CONTROL_OFS, 8'h0A);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk(cellWrite_r, 9'h001);
    wr(CONTROL_OFS, 8'h08);
    n = 0;
    while (cellWrite_r !== 1'b0 && n < 400)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(cellWrite_r, 9'h000);
    chk(rcOscRequest_r, 9'h000);
    @(negedge clk_sys);
    chk(readyIrq_r, 9'h001);
    globalIrqEnable = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(readyIrq_r, 9'h000);
    test_done;
  end
endmodule
bind eeprom_cpu_access_control eeprom_cpu_access_control_asserts
  #(.WRITE_TICKS(WRITE_TICKS)) chk_i (
  .clk_sys(clk_sys), .rst(rst), .porRst(porRst), .clkEn(clkEn),
  .ioAddr(ioAddr), .ioWrite(ioWrite), .ioWdata(ioWdata),
  .ioRdata_r(ioRdata_r), .globalIrqEnable(globalIrqEnable),
  .readyIrq_r(readyIrq_r), .cpuStall_r(cpuStall_r),
  .rcOscRequest_r(rcOscRequest_r), .cellAddr_r(cellAddr_r),
  .cellWdata_r(cellWdata_r), .cellWrite_r(cellWrite_r),
  .cellRead_r(cellRead_r));
`default_nettype wire
